// File: bench/sfcfe_host_model.sv
`timescale 1ns/1ps
module sfcfe_host_model (
	// Clock
	input  wire logic clk,
	// Device lanes
	input  wire logic lane1Out,
	input  wire logic lane1Oe,
	input  wire logic lane0Out,
	input  wire logic lane0Oe,
	// Host drive
	output      logic spiClk,
	output      logic selectN,
	output      logic lane0Drv
);
	logic mosiQ;
	logic hostOe;
	logic oeSeen;
	// Undriven lanes show the inverse of their last bit
	wire  miso = lane1Oe ? lane1Out : ~lane1Out;
	wire  mis0 = lane0Oe ? lane0Out : ~lane0Out;
	assign lane0Drv = hostOe ? mosiQ : ~mosiQ;
	initial begin
		spiClk = 1'b0;
		selectN = 1'b1;
		mosiQ = 1'b0;
		hostOe = 1'b1;
		oeSeen = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic open();
		@(posedge clk);
		selectN <= 1'b0;
		oeSeen <= 1'b0;
		hostOe <= 1'b1;
		tick(4);
	endtask : open
	task automatic xfer(input logic [7:0] tx, input int nb, input logic dual,
		output logic [7:0] rx);
		int steps;
		steps = dual ? 4 : nb;
		hostOe <= !dual;
		for (int i = 0; i < steps; i++) begin
			mosiQ <= tx[7-i];
			tick(4);
			// Sample on the rise, device shifts on the fall
			rx = dual ? {rx[5:0], miso, mis0} : {rx[6:0], miso};
			oeSeen <= oeSeen | lane1Oe;
			spiClk <= 1'b1;
			tick(4);
			spiClk <= 1'b0;
		end
	endtask : xfer
	task automatic close();
		tick(4);
		selectN <= 1'b1;
		hostOe <= 1'b1;
		tick(8);
	endtask : close
endmodule : sfcfe_host_model

// File: bench/sfcfe_properties.sv
`timescale 1ns/1ps
module sfcfe_properties (
	// Clock and reset
	input wire logic                 clk,
	input wire logic                 nrst,
	// APB
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic [11:0]          paddr,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Serial link
	input wire logic                 spiClk,
	input wire logic                 selectN,
	input wire logic                 dualLane0Oe,
	input wire logic                 dualLane1Out,
	input wire logic                 dualLane1Oe,
	// Array engine
	input wire logic                 opStart,
	input wire sfcfe_pkg::sfcfe_op_t opReq,
	input wire logic                 opDone
);
	logic busy_q;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// Engine busy between commit and done
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_q <= 1'b0;
		end else if (opStart) begin
			busy_q <= 1'b1;
		end else if (opDone) begin
			busy_q <= 1'b0;
		end
	end
	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready not a single cycle after setup");
	a_apb_unmapped: assert property (psel && !penable && paddr > 12'h008
		|=> pslverr) else $error("unmapped access without error");
	a_idle_quiet: assert property (selectN [*3] |->
		!dualLane1Oe && !dualLane0Oe) else $error("lane driven while idle");
	a_dual_pair: assert property (dualLane0Oe |-> dualLane1Oe)
		else $error("lane0 driven alone");
	a_shift_fall: assert property (dualLane1Oe &&
		$past(dualLane1Oe) && $changed(dualLane1Out) |-> !$past(spiClk))
		else $error("output changed away from a falling edge");
	a_commit_select: assert property (opStart |-> selectN)
		else $error("commit while selected");
	a_busy_refuse: assert property (opStart |-> !busy_q)
		else $error("commit while operation running");
	a_sector_base: assert property (opStart &&
		opReq.kind == sfcfe_pkg::OP_SECTOR |-> opReq.addr[11:0] == 12'h000)
		else $error("sector erase not on sector base");
	a_block_base: assert property (opStart &&
		opReq.kind == sfcfe_pkg::OP_BLOCK |-> opReq.addr[15:0] == 16'h0000)
		else $error("block erase not on block base");
endmodule : sfcfe_properties
bind sfcfe_top sfcfe_properties props (
	.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .spiClk(spiClk), .selectN(selectN),
	.dualLane0Oe(dualLane0Oe), .dualLane1Out(dualLane1Out),
	.dualLane1Oe(dualLane1Oe), .opStart(opStart), .opReq(opReq),
	.opDone(opDone)
);

// File: bench/tb.sv
`timescale 1ns/1ps
module tb;
	// =========================================================
	// Signals
	logic clk = 1'b0, nrst = 1'b0, guardPinN = 1'b1, opDone = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, prdata;
	logic pready, pslverr, spiClk, selectN, lane0Drv, lane0Wire;
	logic l0Out, l0Oe, l1Out, l1Oe, pgmStrobe, opStart;
	logic [17:0] memRdAddr, pgmAddr;
	logic [25:0] lastPgm = 26'h0000000;
	logic [7:0] memRdData, pgmData;
	logic [15:0] doneCnt = 16'h0000;
	sfcfe_pkg::sfcfe_op_t opReq, lastOp;
	int starts = 0, badCount = 0, compares = 0;
	always #4 clk = ~clk;
	assign lane0Wire = l0Oe ? l0Out : lane0Drv;
	assign memRdData = memRdAddr[7:0] ^ 8'hA5;
	sfcfe_top sfcfe_top_inst (
		.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .spiClk(spiClk),
		.selectN(selectN), .pauseN(1'b1), .guardPinN(guardPinN),
		.dualLane0In(lane0Wire), .dualLane0Out(l0Out), .dualLane0Oe(l0Oe),
		.dualLane1Out(l1Out), .dualLane1Oe(l1Oe), .memRdAddr(memRdAddr),
		.memRdData(memRdData), .pgmStrobe(pgmStrobe), .pgmAddr(pgmAddr),
		.pgmData(pgmData), .opStart(opStart), .opReq(opReq), .opDone(opDone)
	);
	sfcfe_host_model host (
		.clk(clk), .lane1Out(l1Out), .lane1Oe(l1Oe), .lane0Out(l0Out),
		.lane0Oe(l0Oe), .spiClk(spiClk), .selectN(selectN),
		.lane0Drv(lane0Drv)
	);
	// =========================================================
	// Array engine stand-in
	always @(posedge clk) begin
		opDone <= (doneCnt == 16'h0001);
		doneCnt <= opStart ? 16'h0400 : doneCnt - (doneCnt != 16'h0000);
		starts <= starts + opStart;
		if (opStart) lastOp <= opReq;
		if (pgmStrobe) lastPgm <= {pgmData, pgmAddr};
	end
	// =========================================================
	// Shared tasks
	task automatic check(input string what, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			badCount++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (!pready);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic sx(input logic [7:0] tx, output logic [7:0] rx);
		host.xfer(tx, 8, 1'b0, rx);
	endtask : sx
	task automatic cmd(input logic [7:0] op, input int nb, input logic [39:0] ad);
		logic [7:0] rx;
		host.open();
		sx(op, rx);
		for (int i = nb - 1; i >= 0; i--) sx(ad[8*i +: 8], rx);
		host.close();
	endtask : cmd
	task automatic status(output logic [7:0] s);
		host.open();
		sx(sfcfe_pkg::OPC_STFETCH, s);
		sx(8'h00, s);
		host.close();
	endtask : status
	task automatic poll();
		logic [7:0] s = 8'h01;
		for (int i = 0; i < 30 && s[0]; i++) status(s);
		check("pending", s[0], 1'b0);
	endtask : poll
	// =========================================================
	// Scenarios
	task automatic test_apb();
		logic [31:0] rd;
		logic err;
		apb(1'b0, sfcfe_pkg::REG_IDENT, 32'h0, rd, err);
		check("ident", rd, sfcfe_pkg::IDENT_RESET);
		apb(1'b1, sfcfe_pkg::REG_IDENT, 32'hC0FFEE01, rd, err);
		apb(1'b0, sfcfe_pkg::REG_IDENT, 32'h0, rd, err);
		check("ident rw", rd, 32'hC0FFEE01);
		apb(1'b0, 12'h0FC, 32'h0, rd, err);
		check("unmapped", {rd[30:0], err}, 32'h00000001);
	endtask : test_apb
	task automatic test_permit();
		logic [7:0] s;
		status(s);
		check("status reset", s, 8'h00);
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		status(s);
		check("permit set", s, 8'h02);
		cmd(sfcfe_pkg::OPC_CLEAR, 0, 40'h0);
		status(s);
		check("permit clear", s, 8'h00);
		host.open();
		host.xfer(sfcfe_pkg::OPC_GRANT, 8, 1'b0, s);
		host.xfer(8'h00, 4, 1'b0, s);
		host.close();
		status(s);
		check("ragged frame", s, 8'h00);
	endtask : test_permit
	task automatic test_erase();
		logic [7:0] s;
		int n = starts;
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_SECTOR, 3, 40'h012345);
		check("start", starts, n + 1);
		check("kind", lastOp.kind, sfcfe_pkg::OP_SECTOR);
		check("base", lastOp.addr, 18'h12000);
		status(s);
		check("busy", s, 8'h01);
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_SECTOR, 3, 40'h001000);
		check("refused", starts, n + 1);
		poll();
	endtask : test_erase
	task automatic test_guard();
		logic [7:0] s;
		int n;
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_STSTORE, 1, 40'h04);
		status(s);
		check("guard set", s, 8'h04);
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		n = starts;
		cmd(sfcfe_pkg::OPC_BLOCKB, 3, 40'h030000);
		check("top guarded", starts, n);
		cmd(sfcfe_pkg::OPC_BLOCKB, 3, 40'h024567);
		check("block start", starts, n + 1);
		check("block base", lastOp.addr, 18'h20000);
		poll();
		@(posedge clk) guardPinN <= 1'b0;
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_STSTORE, 1, 40'h00);
		status(s);
		check("guard frozen", s[3:2], 2'b01);
		@(posedge clk) guardPinN <= 1'b1;
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_STSTORE, 1, 40'h00);
	endtask : test_guard
	task automatic test_read();
		logic [7:0] rx;
		host.open();
		sx(sfcfe_pkg::OPC_READ, rx);
		for (int i = 2; i >= 0; i--) sx(8'(24'h0001FE >> (8 * i)), rx);
		sx(8'h00, rx);
		check("read 0", rx, 8'h5B);
		sx(8'h00, rx);
		check("read 1", rx, 8'h5A);
		host.close();
		host.open();
		sx(sfcfe_pkg::OPC_TWOLANE, rx);
		for (int i = 0; i < 4; i++) sx(i == 2 ? 8'h10 : 8'h00, rx);
		host.xfer(8'h00, 8, 1'b1, rx);
		check("dual", rx, 8'hB5);
		host.close();
		host.open();
		sx(8'hFF, rx);
		sx(8'h00, rx);
		host.close();
		check("unknown quiet", host.oeSeen, 1'b0);
	endtask : test_read
	task automatic test_sleep();
		logic [7:0] s;
		cmd(sfcfe_pkg::OPC_SLEEP, 0, 40'h0);
		status(s);
		check("asleep", host.oeSeen, 1'b0);
		cmd(sfcfe_pkg::OPC_WAKE, 0, 40'h0);
		status(s);
		check("awake", s, 8'h00);
	endtask : test_sleep
	task automatic test_page();
		int n = starts;
		// Target page lies outside the sector and block erased by earlier steps
		cmd(sfcfe_pkg::OPC_GRANT, 0, 40'h0);
		cmd(sfcfe_pkg::OPC_PAGE, 5, 40'h0000FF1122);
		check("page start", starts, n + 1);
		check("page kind", lastOp.kind, sfcfe_pkg::OP_PAGE);
		check("page wrap", lastPgm, 26'h0880000);
		poll();
	endtask : test_page
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, badCount);
		if (badCount == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize
	// =========================================================
	// Main sequence and watchdog
	initial begin
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		test_apb();
		test_permit();
		test_erase();
		test_guard();
		test_read();
		test_sleep();
		test_page();
		summarize();
	end
	initial begin
		repeat (90000) @(posedge clk);
		badCount++;
		summarize();
	end
endmodule : tb

// File: shared/sfcfe_pkg.sv
package sfcfe_pkg;
	// =========================================================
	// Opcodes
	localparam logic [7:0] OPC_GRANT   = 8'h06;
	localparam logic [7:0] OPC_CLEAR   = 8'h04;
	localparam logic [7:0] OPC_STFETCH = 8'h05;
	localparam logic [7:0] OPC_STSTORE = 8'h01;
	localparam logic [7:0] OPC_READ    = 8'h03;
	localparam logic [7:0] OPC_FAST    = 8'h0B;
	localparam logic [7:0] OPC_TWOLANE = 8'h3B;
	localparam logic [7:0] OPC_SECTOR  = 8'h20;
	localparam logic [7:0] OPC_BLOCKA  = 8'h52;
	localparam logic [7:0] OPC_BLOCKB  = 8'hD8;
	localparam logic [7:0] OPC_CHIPA   = 8'h60;
	localparam logic [7:0] OPC_CHIPB   = 8'hC7;
	localparam logic [7:0] OPC_PAGE    = 8'h02;
	localparam logic [7:0] OPC_SLEEP   = 8'hB9;
	localparam logic [7:0] OPC_WAKE    = 8'hAB;
	localparam logic [7:0] OPC_JEDEC   = 8'h9F;
	localparam logic [7:0] OPC_MAKER   = 8'h90;
	// =========================================================
	// Status byte layout
	localparam int ST_PEND   = 0;
	localparam int ST_PERMIT = 1;
	localparam int ST_GLSB   = 2;
	localparam int ST_GMSB   = 3;
	localparam int ST_LOCK   = 7;
	// =========================================================
	// Array organisation
	localparam int          ARRAY_AW    = 18;
	localparam int          SECTOR_LSB  = 12;
	localparam int          BLOCK_LSB   = 16;
	localparam logic [1:0]  GUARD_NONE  = 2'b00;
	localparam logic [1:0]  GUARD_TOP   = 2'b01;
	localparam logic [1:0]  GUARD_HALF  = 2'b10;
	localparam logic [1:0]  GUARD_ALL   = 2'b11;
	localparam logic [1:0]  TOP_BLOCK   = 2'd3;
	localparam logic [1:0]  HALF_BLOCK  = 2'd2;
	localparam logic [2:0]  BIT_LAST    = 3'd7;
	localparam logic [2:0]  BYTE_SAT    = 3'd7;
	localparam logic [2:0]  ADDR_LAST   = 3'd3;
	localparam logic [2:0]  FIRST_DATA  = 3'd1;
	localparam logic [1:0]  JEDEC_LAST  = 2'd2;
	// =========================================================
	// Register map
	localparam logic [11:0] REG_STATUS  = 12'h000;
	localparam logic [11:0] REG_IDENT   = 12'h004;
	localparam logic [11:0] REG_COUNT   = 12'h008;
	// Arbitrary neutral identity value
	localparam logic [31:0] IDENT_RESET = 32'h5A3C9612;
	// =========================================================
	// Types
	typedef enum logic [2:0] {
		ST_STANDBY = 3'b000,
		ST_CMD     = 3'b001,
		ST_ADDR    = 3'b010,
		ST_DUMMY   = 3'b011,
		ST_DATAOUT = 3'b100,
		ST_DATAIN  = 3'b101,
		ST_WAIT    = 3'b110,
		ST_IGNORE  = 3'b111
	} sfcfe_state_t;
	typedef enum logic [2:0] {
		OP_NONE   = 3'b000,
		OP_PAGE   = 3'b001,
		OP_SECTOR = 3'b010,
		OP_BLOCK  = 3'b011,
		OP_CHIP   = 3'b100
	} sfcfe_kind_t;
	typedef struct packed {
		sfcfe_kind_t           kind;
		logic [ARRAY_AW-1:0]   addr;
	} sfcfe_op_t;
endpackage : sfcfe_pkg

// File: verilog/sfcfe_top.sv
// Functional notes
// - Target in clock modes 0 and 3
// - Sample on rise, shift out on fall
// - 64 sectors of 4K, each erasable
// - 4 blocks of 64K, block 3 top
// - Two-lane read drives both lanes
// - Pending flag shows running program/erase
// - Select high and idle means standby
// - Unknown opcode: ignored until select rises
// - Valid opcode: active until select rises
// - Read phases end on any select rise
// - Write-type commands need byte-aligned select rise
// - Array access ignored while operation runs
// - Reset returns machine to standby
// - Content changes need permit latch set
// - Permit cleared on reset and completions
// - Sleep ignores all but wake/signature
// - Guard level bits block program/erase
// - Low guard pin freezes guard/lock bits
// - One-byte opcode starts every command
// - Pause suspends link, not operations
`timescale 1ns/1ps
module sfcfe_top (
	// Clock and reset
	input  wire logic                 clk,
	input  wire logic                 nrst,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output      logic [31:0]          prdata,
	output      logic                 pready,
	output      logic                 pslverr,
	// Serial link
	input  wire logic                 spiClk,
	input  wire logic                 selectN,
	input  wire logic                 pauseN,
	input  wire logic                 guardPinN,
	input  wire logic                 dualLane0In,
	output      logic                 dualLane0Out,
	output      logic                 dualLane0Oe,
	output      logic                 dualLane1Out,
	output      logic                 dualLane1Oe,
	// Array engine
	output      logic [17:0]          memRdAddr,
	input  wire logic [7:0]           memRdData,
	output      logic                 pgmStrobe,
	output      logic [17:0]          pgmAddr,
	output      logic [7:0]           pgmData,
	output      logic                 opStart,
	output      sfcfe_pkg::sfcfe_op_t opReq,
	input  wire logic                 opDone
);
	// =========================================================
	// State
	sfcfe_pkg::sfcfe_state_t state_q, state_d;
	sfcfe_pkg::sfcfe_op_t    opReq_q, opReq_d;
	logic        sclkPrev_q, selPrev_q, pause_q, pause_d;
	logic [2:0]  bitCnt_q, bitCnt_d, byteCnt_q, byteCnt_d;
	logic [2:0]  outPos_q, outPos_d;
	logic [7:0]  shIn_q, shIn_d, shOut_q, shOut_d, opc_q, opc_d;
	logic [23:0] addr_q, addr_d;
	logic [17:0] rdAddr_q, rdAddr_d, pgmAddr_q, pgmAddr_d;
	logic [7:0]  pgmData_q, pgmData_d, stNew_q, stNew_d;
	logic [1:0]  idx_q, idx_d, guard_q, guard_d;
	logic        pend_q, pend_d, permit_q, permit_d, lock_q, lock_d;
	logic        sleep_q, sleep_d, hasData_q, hasData_d;
	logic        pgmStb_q, pgmStb_d, opStart_q, opStart_d;
	logic        l0_q, l0_d, l1_q, l1_d, oe0_q, oe0_d, oe1_q, oe1_d;
	logic        txOn_q, txOn_d;
	logic [31:0] ident_q, ident_d, prdata_q, prdata_d;
	logic [15:0] cnt_q, cnt_d;
	logic        pready_q, pslverr_q, pslverr_d;
	// =========================================================
	// Edge detection and decode
	wire sclkRise = spiClk && !sclkPrev_q;
	wire sclkFall = !spiClk && sclkPrev_q;
	wire selFall  = !selectN && selPrev_q;
	wire selRise  = selectN && !selPrev_q;
	wire linkOn   = !selectN && !pause_q;
	wire rxEn     = linkOn && sclkRise;
	wire txEn     = linkOn && sclkFall && state_q == sfcfe_pkg::ST_DATAOUT;
	wire [7:0] rxByte  = {shIn_q[6:0], dualLane0In};
	wire       byteEnd = rxEn && bitCnt_q == sfcfe_pkg::BIT_LAST;
	wire [23:0] addrFull = {addr_q[15:0], rxByte};
	wire [7:0] opcIn   = rxByte;
	wire isRead  = opc_q == sfcfe_pkg::OPC_READ ||
		opc_q == sfcfe_pkg::OPC_FAST || opc_q == sfcfe_pkg::OPC_TWOLANE;
	wire isDual  = opc_q == sfcfe_pkg::OPC_TWOLANE;
	wire isBlk   = opc_q == sfcfe_pkg::OPC_BLOCKA ||
		opc_q == sfcfe_pkg::OPC_BLOCKB;
	wire isChip  = opc_q == sfcfe_pkg::OPC_CHIPA ||
		opc_q == sfcfe_pkg::OPC_CHIPB;
	wire inArray = opcIn == sfcfe_pkg::OPC_READ ||
		opcIn == sfcfe_pkg::OPC_FAST || opcIn == sfcfe_pkg::OPC_TWOLANE ||
		opcIn == sfcfe_pkg::OPC_SECTOR || opcIn == sfcfe_pkg::OPC_BLOCKA ||
		opcIn == sfcfe_pkg::OPC_BLOCKB || opcIn == sfcfe_pkg::OPC_CHIPA ||
		opcIn == sfcfe_pkg::OPC_CHIPB || opcIn == sfcfe_pkg::OPC_PAGE;
	wire inChange = inArray && opcIn != sfcfe_pkg::OPC_READ &&
		opcIn != sfcfe_pkg::OPC_FAST && opcIn != sfcfe_pkg::OPC_TWOLANE;
	wire [1:0] blkSel = addrFull[sfcfe_pkg::BLOCK_LSB+1:sfcfe_pkg::BLOCK_LSB];
	wire guarded = guard_q == sfcfe_pkg::GUARD_ALL ||
		(guard_q == sfcfe_pkg::GUARD_HALF && blkSel >= sfcfe_pkg::HALF_BLOCK) ||
		(guard_q == sfcfe_pkg::GUARD_TOP && blkSel == sfcfe_pkg::TOP_BLOCK);
	wire [7:0] statusByte = {lock_q, 3'b000, guard_q, permit_q, pend_q};
	wire aligned  = bitCnt_q == 3'd0;
	wire wakeDone = opc_q == sfcfe_pkg::OPC_WAKE &&
		(aligned || state_q == sfcfe_pkg::ST_DATAOUT);
	wire commit   = selRise && aligned &&
		(state_q == sfcfe_pkg::ST_WAIT ||
		(state_q == sfcfe_pkg::ST_DATAIN && hasData_q));
	// Sector/block bases cover contiguous ranges
	wire [17:0] secBase = {addrFull[17:sfcfe_pkg::SECTOR_LSB],
		{sfcfe_pkg::SECTOR_LSB{1'b0}}};
	wire [17:0] blkBase = {addrFull[17:sfcfe_pkg::BLOCK_LSB],
		{sfcfe_pkg::BLOCK_LSB{1'b0}}};
	// =========================================================
	// Outgoing byte source
	logic [7:0] srcByte;
	always_comb begin
		srcByte = ident_q[31:24];
		if (opc_q == sfcfe_pkg::OPC_STFETCH) begin
			srcByte = statusByte;
		end else if (isRead) begin
			srcByte = memRdData;
		end else if (opc_q == sfcfe_pkg::OPC_JEDEC) begin
			case (idx_q)
				2'd0:    srcByte = ident_q[7:0];
				2'd1:    srcByte = ident_q[15:8];
				default: srcByte = ident_q[23:16];
			endcase
		end else if (opc_q == sfcfe_pkg::OPC_MAKER) begin
			srcByte = idx_q[0] ? ident_q[31:24] : ident_q[7:0];
		end
	end
	// =========================================================
	// Command framing
	always_comb begin
		state_d   = state_q;
		bitCnt_d  = bitCnt_q;
		byteCnt_d = byteCnt_q;
		shIn_d    = shIn_q;
		opc_d     = opc_q;
		addr_d    = addr_q;
		rdAddr_d  = rdAddr_q;
		pgmAddr_d = pgmAddr_q;
		pgmData_d = pgmData_q;
		pgmStb_d  = 1'b0;
		stNew_d   = stNew_q;
		hasData_d = hasData_q;
		idx_d     = idx_q;
		opReq_d   = opReq_q;
		cnt_d     = cnt_q;
		if (selectN) begin
			state_d   = sfcfe_pkg::ST_STANDBY;
			bitCnt_d  = 3'd0;
			byteCnt_d = 3'd0;
		end else if (selFall) begin
			state_d   = sfcfe_pkg::ST_CMD;
			bitCnt_d  = 3'd0;
			byteCnt_d = 3'd0;
			hasData_d = 1'b0;
			idx_d     = 2'd0;
		end else if (rxEn) begin
			shIn_d   = rxByte;
			bitCnt_d = bitCnt_q + 3'd1;
			if (byteEnd && byteCnt_q != sfcfe_pkg::BYTE_SAT) begin
				byteCnt_d = byteCnt_q + 3'd1;
			end
			if (byteEnd) begin
				case (state_q)
					sfcfe_pkg::ST_CMD: begin
						opc_d   = opcIn;
						state_d = sfcfe_pkg::ST_IGNORE;
						if (sleep_q && opcIn != sfcfe_pkg::OPC_WAKE) begin
							state_d = sfcfe_pkg::ST_IGNORE;
						end else if (pend_q && inArray) begin
							state_d = sfcfe_pkg::ST_IGNORE;
						end else if (inChange && !permit_q) begin
							state_d = sfcfe_pkg::ST_IGNORE;
						end else begin
							case (opcIn)
								sfcfe_pkg::OPC_GRANT,
								sfcfe_pkg::OPC_CLEAR,
								sfcfe_pkg::OPC_SLEEP:
									state_d = sfcfe_pkg::ST_WAIT;
								sfcfe_pkg::OPC_CHIPA,
								sfcfe_pkg::OPC_CHIPB:
									state_d = guard_q == sfcfe_pkg::GUARD_NONE ?
										sfcfe_pkg::ST_WAIT : sfcfe_pkg::ST_IGNORE;
								sfcfe_pkg::OPC_STSTORE: begin
									if (permit_q) begin
										state_d = sfcfe_pkg::ST_DATAIN;
									end
								end
								sfcfe_pkg::OPC_STFETCH,
								sfcfe_pkg::OPC_JEDEC:
									state_d = sfcfe_pkg::ST_DATAOUT;
								sfcfe_pkg::OPC_READ, sfcfe_pkg::OPC_FAST,
								sfcfe_pkg::OPC_TWOLANE, sfcfe_pkg::OPC_SECTOR,
								sfcfe_pkg::OPC_BLOCKA, sfcfe_pkg::OPC_BLOCKB,
								sfcfe_pkg::OPC_PAGE, sfcfe_pkg::OPC_MAKER,
								sfcfe_pkg::OPC_WAKE:
									state_d = sfcfe_pkg::ST_ADDR;
								default:
									state_d = sfcfe_pkg::ST_IGNORE;
							endcase
						end
						if (state_d != sfcfe_pkg::ST_IGNORE) begin
							cnt_d = cnt_q + 16'h0001;
						end
					end
					sfcfe_pkg::ST_ADDR: begin
						addr_d = addrFull;
						if (byteCnt_q == sfcfe_pkg::ADDR_LAST) begin
							rdAddr_d  = addrFull[17:0];
							pgmAddr_d = {addrFull[17:8], addrFull[7:0] - 8'h01};
							idx_d     = {1'b0, rxByte[0]};
							if (isRead && opc_q != sfcfe_pkg::OPC_READ) begin
								state_d = sfcfe_pkg::ST_DUMMY;
							end else if (opc_q == sfcfe_pkg::OPC_SECTOR ||
								isBlk || opc_q == sfcfe_pkg::OPC_PAGE) begin
								state_d = guarded ? sfcfe_pkg::ST_IGNORE :
									(opc_q == sfcfe_pkg::OPC_PAGE ?
									sfcfe_pkg::ST_DATAIN : sfcfe_pkg::ST_WAIT);
								opReq_d.addr = opc_q == sfcfe_pkg::OPC_SECTOR ?
									secBase : (isBlk ? blkBase : addrFull[17:0]);
							end else begin
								state_d = sfcfe_pkg::ST_DATAOUT;
							end
						end
					end
					sfcfe_pkg::ST_DUMMY:
						state_d = sfcfe_pkg::ST_DATAOUT;
					sfcfe_pkg::ST_DATAIN: begin
						hasData_d = 1'b1;
						if (byteCnt_q == sfcfe_pkg::FIRST_DATA) begin
							stNew_d = rxByte;
						end
						if (opc_q == sfcfe_pkg::OPC_PAGE) begin
							pgmStb_d  = 1'b1;
							pgmData_d = rxByte;
							pgmAddr_d = {pgmAddr_q[17:8], pgmAddr_q[7:0] + 8'h01};
						end
					end
					default: state_d = state_q;
				endcase
			end
		end
		if (txEn && outPos_q == 3'd0) begin
			if (isRead) begin
				rdAddr_d = rdAddr_q + 18'h00001;
			end
			idx_d = (opc_q == sfcfe_pkg::OPC_JEDEC &&
				idx_q == sfcfe_pkg::JEDEC_LAST) ? 2'd0 : idx_q + 2'd1;
		end
		if (opStart_d) begin
			opReq_d.kind = opc_q == sfcfe_pkg::OPC_PAGE ?
				sfcfe_pkg::OP_PAGE : (opc_q == sfcfe_pkg::OPC_SECTOR ?
				sfcfe_pkg::OP_SECTOR : (isChip ? sfcfe_pkg::OP_CHIP :
				sfcfe_pkg::OP_BLOCK));
		end
	end
	// =========================================================
	// Data-out shifter
	wire [7:0] curByte = outPos_q == 3'd0 ? srcByte : shOut_q;
	always_comb begin
		shOut_d  = shOut_q;
		outPos_d = outPos_q;
		l0_d     = l0_q;
		l1_d     = l1_q;
		txOn_d   = txOn_q;
		if (state_q != sfcfe_pkg::ST_DATAOUT || selectN) begin
			outPos_d = 3'd0;
			txOn_d   = 1'b0;
		end else if (txEn) begin
			txOn_d = 1'b1;
			l1_d   = curByte[7];
			if (isDual) begin
				l0_d     = curByte[6];
				shOut_d  = {curByte[5:0], 2'b00};
				outPos_d = outPos_q + 3'd2;
			end else begin
				shOut_d  = {curByte[6:0], 1'b0};
				outPos_d = outPos_q + 3'd1;
			end
		end
		// Drivers drop on select rise or pause
		oe1_d = txOn_d && !selectN && !pause_d;
		oe0_d = oe1_d && isDual;
	end
	// =========================================================
	// Status, permit and sleep
	always_comb begin
		pend_d    = pend_q;
		permit_d  = permit_q;
		guard_d   = guard_q;
		lock_d    = lock_q;
		sleep_d   = sleep_q;
		opStart_d = 1'b0;
		pause_d   = pause_q;
		if (selectN) begin
			pause_d = 1'b0;
		end else if (!spiClk) begin
			pause_d = !pauseN;
		end
		if (opDone) begin
			pend_d = 1'b0;
		end
		if (selRise && wakeDone) begin
			sleep_d = 1'b0;
		end
		if (commit) begin
			case (opc_q)
				sfcfe_pkg::OPC_GRANT: permit_d = 1'b1;
				sfcfe_pkg::OPC_CLEAR: permit_d = 1'b0;
				sfcfe_pkg::OPC_SLEEP: sleep_d  = 1'b1;
				sfcfe_pkg::OPC_STSTORE: begin
					permit_d = 1'b0;
					if (guardPinN) begin
						guard_d = {stNew_q[sfcfe_pkg::ST_GMSB],
							stNew_q[sfcfe_pkg::ST_GLSB]};
						lock_d  = stNew_q[sfcfe_pkg::ST_LOCK];
					end
				end
				sfcfe_pkg::OPC_SECTOR, sfcfe_pkg::OPC_BLOCKA,
				sfcfe_pkg::OPC_BLOCKB, sfcfe_pkg::OPC_CHIPA,
				sfcfe_pkg::OPC_CHIPB, sfcfe_pkg::OPC_PAGE: begin
					permit_d  = 1'b0;
					pend_d    = 1'b1;
					opStart_d = 1'b1;
				end
				default: permit_d = permit_q;
			endcase
		end
	end
	// =========================================================
	// APB slave
	wire apbSetup  = psel && !penable;
	wire apbWrite  = psel && penable && pready_q && pwrite;
	wire hitStatus = paddr == sfcfe_pkg::REG_STATUS;
	wire hitIdent  = paddr == sfcfe_pkg::REG_IDENT;
	wire hitCount  = paddr == sfcfe_pkg::REG_COUNT;
	wire hitAny    = hitStatus || hitIdent || hitCount;
	assign ident_d = (apbWrite && hitIdent) ? pwdata : ident_q;
	assign prdata_d = !apbSetup ? prdata_q :
		(pwrite ? 32'h00000000 :
		(hitStatus ? {19'h00000, state_q, pause_q, sleep_q, statusByte} :
		(hitIdent ? ident_q :
		(hitCount ? {16'h0000, cnt_q} : 32'h00000000))));
	assign pslverr_d = apbSetup ? !hitAny : pslverr_q;
	// =========================================================
	// Registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q  <= sfcfe_pkg::ST_STANDBY;
			opReq_q  <= '0;
			{sclkPrev_q, selPrev_q, pause_q} <= 3'b010;
			{bitCnt_q, byteCnt_q, outPos_q} <= 9'h000;
			{shIn_q, shOut_q, opc_q, pgmData_q, stNew_q} <= 40'h0000000000;
			addr_q   <= 24'h000000;
			{rdAddr_q, pgmAddr_q} <= 36'h000000000;
			{idx_q, guard_q} <= 4'h0;
			{pend_q, permit_q, lock_q, sleep_q, hasData_q} <= 5'h00;
			{pgmStb_q, opStart_q, txOn_q} <= 3'b000;
			{l0_q, l1_q, oe0_q, oe1_q} <= 4'h0;
			ident_q  <= sfcfe_pkg::IDENT_RESET;
			prdata_q <= 32'h00000000;
			cnt_q    <= 16'h0000;
			{pready_q, pslverr_q} <= 2'b00;
		end else begin
			state_q  <= state_d;
			opReq_q  <= opReq_d;
			{sclkPrev_q, selPrev_q, pause_q} <= {spiClk, selectN, pause_d};
			{bitCnt_q, byteCnt_q, outPos_q} <= {bitCnt_d, byteCnt_d, outPos_d};
			{shIn_q, shOut_q, opc_q} <= {shIn_d, shOut_d, opc_d};
			{pgmData_q, stNew_q} <= {pgmData_d, stNew_d};
			addr_q   <= addr_d;
			{rdAddr_q, pgmAddr_q} <= {rdAddr_d, pgmAddr_d};
			{idx_q, guard_q} <= {idx_d, guard_d};
			{pend_q, permit_q, lock_q} <= {pend_d, permit_d, lock_d};
			{sleep_q, hasData_q} <= {sleep_d, hasData_d};
			{pgmStb_q, opStart_q, txOn_q} <= {pgmStb_d, opStart_d, txOn_d};
			{l0_q, l1_q, oe0_q, oe1_q} <= {l0_d, l1_d, oe0_d, oe1_d};
			ident_q  <= ident_d;
			prdata_q <= prdata_d;
			cnt_q    <= cnt_d;
			{pready_q, pslverr_q} <= {apbSetup, pslverr_d};
		end
	end
	// =========================================================
	// Outputs
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign dualLane0Out = l0_q;
	assign dualLane0Oe  = oe0_q;
	assign dualLane1Out = l1_q;
	assign dualLane1Oe  = oe1_q;
	assign memRdAddr    = rdAddr_q;
	assign pgmStrobe    = pgmStb_q;
	assign pgmAddr      = pgmAddr_q;
	assign pgmData      = pgmData_q;
	assign opStart      = opStart_q;
	assign opReq        = opReq_q;
endmodule : sfcfe_top
